// *** logic/nrd_regs.vh ***
// Purpose: command codes, feature addresses and counts of the read engine
// Assumes: included by the design files of the nrd block only
// Notes:   definitions only
`ifndef NRD_REGS_VH
`define NRD_REGS_VH

// command opcodes, all sent single-rate on sio[0]
`define NRD_CMD_READ_ID   8'h9f
`define NRD_CMD_GET_FEAT  8'h0f
`define NRD_CMD_SET_FEAT  8'h1f
`define NRD_CMD_PAGE_RD   8'h13
`define NRD_CMD_RD_CACHE  8'h03
`define NRD_CMD_RD_FAST   8'h0b
`define NRD_CMD_RD_DTR    8'hee

// feature addresses and fields
`define NRD_FEAT_CFG      8'hb0
`define NRD_FEAT_STATUS   8'hc0
`define NRD_CFG_RESET     8'h00
`define NRD_CFG_QE_BIT    0
`define NRD_CFG_OTP_BIT   6
`define NRD_STAT_BUSY_BIT 0
`define NRD_ID_ADDR       8'h00

// array geometry
`define NRD_UID_ROW       24'h000006
`define NRD_UID_SPAN      12'h200
`define NRD_LAST_COL      12'h87f

// address lengths in bits, dtr address in nibbles, dummy clocks
`define NRD_ABITS_FEAT    5'h08
`define NRD_ABITS_SETF    5'h10
`define NRD_ABITS_ROW     5'h18
`define NRD_ABITS_COL     5'h10
`define NRD_ANIB_DTR      5'h04
`define NRD_DUMMY_SDR     5'h08
`define NRD_DUMMY_DTR     5'h04

`endif

// *** logic/nrd_sync.v ***
// Purpose: two-flop synchroniser for pins from outside clk_sys
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module nrd_sync #(
  parameter           W       = 6,
  parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         clk_en,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (clk_en) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

endmodule // nrd_sync

// *** logic/nrd_fifo.v ***
// Purpose: first-word-fall-through fifo between cache and output shifter
// Assumes: DEPTH is a power of two
// Notes:   flush empties it in one cycle
`timescale 1ns/1ps
module nrd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             clk_en,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam            AW   = $clog2(DEPTH);
  localparam [AW:0]     FULL = DEPTH;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wp_q;
  reg  [AW-1:0]    rp_q;
  reg  [AW:0]      cnt_q;
  wire             push;
  wire             pop;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always @(posedge clk_sys) begin
    if (clk_en & push)
      mem[wp_q] <= in_data;
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (flush) begin
        wp_q  <= {AW{1'b0}};
        rp_q  <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
      end else begin
        if (push)
          wp_q <= wp_q + 1'b1;
        if (pop)
          rp_q <= rp_q + 1'b1;
        if (push & ~pop)
          cnt_q <= cnt_q + 1'b1;
        else if (pop & ~push)
          cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // nrd_fifo

// *** logic/nrd_top.v ***
// Purpose: read-side command engine of a serial nand (cache, id, uid)
// Assumes: spi mode 0 host; sclk half period of at least 6 clk_sys cycles
// Notes:   array contents are synthesised; no program or erase path
`timescale 1ns/1ps
`include "nrd_regs.vh"

// Function
// (R1) host sets quad_lines_enable_bit before issuing double_rate_quad_read
// (R2) dtr address comes four bits per edge, both sclk edges
// (R3) dtr read gives a byte per clock: high nibble rise, low fall
// (R4) any start column; column advances one per output byte
// (R5) column wraps from the highest address to zero and continues
// (R6) id command with address 00h returns maker code then part_code
// (R7) unique_identifier bytes 0-15, its bitwise inverse in 16-31
// (R8) sixteen consecutive copies of identifier plus inverse record
// (R9) host accepts a copy only when identifier xor inverse is all ones
// (R10) host enables otp access in configuration_feature_register and checks
// (R11) host issues page read 13h to row 6, loading identifier to cache
// (R12) host polls status with 0fh, then reads cache with 03h or 0bh
// (R13) during array to cache load status shows busy, cache data invalid
module nrd_top #(
  parameter             COL_W      = 12,
  parameter [COL_W-1:0] LAST_COL   = `NRD_LAST_COL,
  parameter [4:0]       DTR_DUMMY  = `NRD_DUMMY_DTR,
  parameter             FIFO_DEPTH = 8,
  // identity values below are arbitrary
  parameter [7:0]       MAKER_CODE = 8'h5a,
  parameter [7:0]       PART_CODE  = 8'h3c,
  parameter [127:0]     UID_VALUE  = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       clk_en,
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire [3:0] sio_in,
  output reg  [3:0] sio_out_q,
  output reg  [3:0] sio_oe_q,
  output reg        busy_q
);

  localparam [2:0] ST_CMD   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_OUT   = 3'h3;
  localparam [2:0] ST_IGN   = 3'h4;

  // synchronised pins
  wire [5:0]       pin_s;
  wire             sclk_s;
  wire             cs_s;
  wire [3:0]       sio_s;
  reg              sclk_d_q;
  reg              cs_d_q;
  wire             rise;
  wire             fall;
  wire             cs_rise;

  // frame engine
  reg  [2:0]       st_q;
  reg  [7:0]       cmd_q;
  reg  [23:0]      sh_q;
  reg  [23:0]      sh_nx;
  reg  [4:0]       cnt_q;
  wire [4:0]       cnt_inc;
  reg  [4:0]       need_q;
  reg  [4:0]       cmd_need;
  reg              cmd_ok;
  reg  [2:0]       bit_q;
  reg  [7:0]       byte_q;
  reg              alt_q;
  wire             dtr;
  wire             addr_edge;
  wire             load;
  reg  [7:0]       src_byte;
  reg  [7:0]       stat_byte;
  reg  [7:0]       config_q;
  reg  [23:0]      row_q;
  reg              ld_arm_q;

  // cache, loader and prefetch
  reg  [7:0]       cache_mem [0:LAST_COL];
  reg  [COL_W-1:0] ld_col_q;
  reg  [7:0]       ld_row_q;
  reg              ld_uid_q;
  reg  [7:0]       ld_byte;
  reg  [7:0]       uid_b;
  reg  [COL_W-1:0] rd_col_q;
  reg              rd_en_q;
  wire             cache_cmd;
  wire             fifo_iv;
  wire             fifo_ir;
  wire             fifo_push;
  wire             fifo_ov;
  wire [7:0]       fifo_od;
  wire             fifo_pop;

  nrd_sync #(
    .W       (6),
    .RST_VAL (6'h10)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pin_in  ({spi_sclk, spi_cs_n, sio_in}),
    .sync_q  (pin_s)
  );

  assign sclk_s  = pin_s[5];
  assign cs_s    = pin_s[4];
  assign sio_s   = pin_s[3:0];
  assign rise    = sclk_s & ~sclk_d_q;
  assign fall    = ~sclk_s & sclk_d_q;
  assign cs_rise = cs_s & ~cs_d_q;
  assign cnt_inc = cnt_q + 5'h01;

  // cmd_q is stale while the opcode is still shifting in
  assign dtr       = (st_q != ST_CMD) && (cmd_q == `NRD_CMD_RD_DTR);
  assign addr_edge = dtr ? (rise | fall) : rise; // R2
  assign load      = (st_q == ST_OUT) & fall & (dtr | (bit_q == 3'h0));
  assign cache_cmd = (cmd_q == `NRD_CMD_RD_CACHE) |
                     (cmd_q == `NRD_CMD_RD_FAST) |
                     (cmd_q == `NRD_CMD_RD_DTR);
  assign fifo_iv   = rd_en_q & ~busy_q; // R13
  assign fifo_push = fifo_iv & fifo_ir;
  assign fifo_pop  = load & cache_cmd & ~busy_q;

  always @* begin
    if (dtr)
      sh_nx = {sh_q[19:0], sio_s}; // R2
    else
      sh_nx = {sh_q[22:0], sio_s[0]};
  end

  // opcode decode; unknown opcodes park the frame
  always @* begin
    cmd_ok   = 1'b1;
    cmd_need = `NRD_ABITS_COL;
    case (sh_nx[7:0])
      `NRD_CMD_READ_ID:  cmd_need = `NRD_ABITS_FEAT;
      `NRD_CMD_GET_FEAT: cmd_need = `NRD_ABITS_FEAT;
      `NRD_CMD_SET_FEAT: cmd_need = `NRD_ABITS_SETF;
      `NRD_CMD_PAGE_RD:  cmd_need = `NRD_ABITS_ROW;
      `NRD_CMD_RD_CACHE: cmd_need = `NRD_ABITS_COL;
      `NRD_CMD_RD_FAST:  cmd_need = `NRD_ABITS_COL;
      `NRD_CMD_RD_DTR: begin
        cmd_need = `NRD_ANIB_DTR;
        cmd_ok   = config_q[`NRD_CFG_QE_BIT]; // R1
      end
      default:           cmd_ok   = 1'b0;
    endcase
  end

  always @* begin
    stat_byte = 8'h00;
    stat_byte[`NRD_STAT_BUSY_BIT] = busy_q; // R13
    case (cmd_q)
      `NRD_CMD_READ_ID: begin
        if (sh_q[7:0] != `NRD_ID_ADDR)
          src_byte = 8'h00;
        else if (alt_q)
          src_byte = PART_CODE; // R6
        else
          src_byte = MAKER_CODE; // R6
      end
      `NRD_CMD_GET_FEAT: begin
        if (sh_q[7:0] == `NRD_FEAT_CFG)
          src_byte = config_q;
        else if (sh_q[7:0] == `NRD_FEAT_STATUS)
          src_byte = stat_byte; // R12
        else
          src_byte = 8'h00;
      end
      default: begin
        // no valid byte while loading or if prefetch fell behind
        if (busy_q | ~fifo_ov)
          src_byte = 8'hff; // R13
        else
          src_byte = fifo_od;
      end
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_q  <= 1'b0;
      cs_d_q    <= 1'b1;
      st_q      <= ST_CMD;
      cmd_q     <= 8'h00;
      sh_q      <= 24'h000000;
      cnt_q     <= 5'h00;
      need_q    <= 5'h00;
      bit_q     <= 3'h0;
      byte_q    <= 8'h00;
      alt_q     <= 1'b0;
      config_q  <= `NRD_CFG_RESET;
      row_q     <= 24'h000000;
      ld_arm_q  <= 1'b0;
      rd_col_q  <= {COL_W{1'b0}};
      rd_en_q   <= 1'b0;
      sio_out_q <= 4'h0;
      sio_oe_q  <= 4'h0;
    end else if (clk_en) begin
      sclk_d_q <= sclk_s;
      cs_d_q   <= cs_s;
      if (fifo_push) begin
        if (rd_col_q == LAST_COL)
          rd_col_q <= {COL_W{1'b0}}; // R5
        else
          rd_col_q <= rd_col_q + 1'b1; // R4
      end
      if (cs_s) begin
        st_q      <= ST_CMD;
        cnt_q     <= 5'h00;
        bit_q     <= 3'h0;
        alt_q     <= 1'b0;
        rd_en_q   <= 1'b0;
        ld_arm_q  <= 1'b0;
        sio_out_q <= 4'h0;
        sio_oe_q  <= 4'h0;
      end else begin
        case (st_q)
          ST_CMD: begin
            if (rise) begin
              sh_q  <= sh_nx;
              cnt_q <= cnt_inc;
              if (cnt_q == 5'h07) begin
                cmd_q  <= sh_nx[7:0];
                cnt_q  <= 5'h00;
                need_q <= cmd_need;
                st_q   <= cmd_ok ? ST_ADDR : ST_IGN; // R1
              end
            end
          end
          ST_ADDR: begin
            if (addr_edge) begin
              sh_q  <= sh_nx;
              cnt_q <= cnt_inc;
              if (cnt_inc == need_q) begin
                cnt_q <= 5'h00;
                case (cmd_q)
                  `NRD_CMD_READ_ID:  st_q <= ST_OUT;
                  `NRD_CMD_GET_FEAT: st_q <= ST_OUT;
                  `NRD_CMD_SET_FEAT: begin
                    if (sh_nx[15:8] == `NRD_FEAT_CFG)
                      config_q <= sh_nx[7:0];
                    st_q <= ST_IGN;
                  end
                  `NRD_CMD_PAGE_RD: begin
                    row_q    <= sh_nx;
                    ld_arm_q <= 1'b1;
                    st_q     <= ST_IGN;
                  end
                  default: begin
                    rd_col_q <= sh_nx[COL_W-1:0]; // R4
                    rd_en_q  <= 1'b1;
                    st_q     <= ST_DUMMY;
                  end
                endcase
              end
            end
          end
          ST_DUMMY: begin
            if (rise) begin
              cnt_q <= cnt_inc;
              if (cnt_inc == (dtr ? DTR_DUMMY : `NRD_DUMMY_SDR)) begin
                cnt_q <= 5'h00;
                st_q  <= ST_OUT;
              end
            end
          end
          ST_OUT: begin
            if (load) begin
              alt_q <= ~alt_q;
              if (dtr) begin
                byte_q    <= src_byte;
                sio_out_q <= src_byte[7:4]; // R3
                sio_oe_q  <= 4'hf;
              end else begin
                byte_q    <= {src_byte[6:0], 1'b0};
                sio_out_q <= {2'b00, src_byte[7], 1'b0};
                sio_oe_q  <= 4'h2;
                bit_q     <= 3'h1;
              end
            end else if (fall) begin
              byte_q    <= {byte_q[6:0], 1'b0};
              sio_out_q <= {2'b00, byte_q[7], 1'b0};
              bit_q     <= bit_q + 3'h1;
            end else if (rise & dtr) begin
              sio_out_q <= byte_q[3:0]; // R3
            end
          end
          ST_IGN: st_q <= ST_IGN;
          default: st_q <= ST_IGN;
        endcase
      end
    end
  end

  // identifier record: 16 bytes, then their inverse, repeated
  always @* begin
    uid_b = UID_VALUE[{~ld_col_q[3:0], 3'b000} +: 8]; // R7
    if (ld_uid_q) begin
      if (ld_col_q >= `NRD_UID_SPAN)
        ld_byte = 8'hff;
      else if (ld_col_q[4])
        ld_byte = ~uid_b; // R7
      else
        ld_byte = uid_b; // R8
    end else begin
      ld_byte = ld_row_q ^ ld_col_q[7:0];
    end
  end

  // load runs after deselect, one byte a cycle, so busy lasts a full page
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q   <= 1'b0;
      ld_col_q <= {COL_W{1'b0}};
      ld_row_q <= 8'h00;
      ld_uid_q <= 1'b0;
    end else if (clk_en) begin
      if (busy_q) begin
        if (ld_col_q == LAST_COL)
          busy_q <= 1'b0; // R13
        ld_col_q <= ld_col_q + 1'b1;
      end else if (cs_rise & ld_arm_q) begin
        busy_q   <= 1'b1; // R13
        ld_col_q <= {COL_W{1'b0}};
        ld_row_q <= row_q[7:0];
        ld_uid_q <= config_q[`NRD_CFG_OTP_BIT] &
                    (row_q == `NRD_UID_ROW); // R11
      end
    end
  end

  always @(posedge clk_sys) begin
    if (clk_en & busy_q)
      cache_mem[ld_col_q] <= ld_byte;
  end

  nrd_fifo #(
    .WIDTH     (8),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .flush     (cs_s),
    .in_valid  (fifo_iv),
    .in_ready  (fifo_ir),
    .in_data   (cache_mem[rd_col_q]),
    .out_valid (fifo_ov),
    .out_ready (fifo_pop),
    .out_data  (fifo_od)
  );

endmodule // nrd_top

// *** tb/nrd_props.sv ***
// Purpose: port checks of nrd_top
// Assumes: busy lasts 2176 cycles; sclk half period of 8 cycles
// Notes:   bound to nrd_top at the foot
`timescale 1ns/1ps
module nrd_props (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire       clk_en,
  input wire       spi_sclk,
  input wire       spi_cs_n,
  input wire [3:0] sio_in,
  input wire [3:0] sio_out_q,
  input wire [3:0] sio_oe_q,
  input wire       busy_q
);
  // counts busy cycles; frozen with clk_en like the design
  reg [11:0] bcnt_q;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) bcnt_q <= 12'h000;
    else if (clk_en) bcnt_q <= busy_q ? bcnt_q + 12'h001 : 12'h000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_oe_legal: assert property (
    sio_oe_q == 4'h0 || sio_oe_q == 4'h2 || sio_oe_q == 4'hf)
    else $error("bad oe");
  a_oe_idle: assert property (
    spi_cs_n [*8] |-> sio_oe_q == 4'h0) else $error("oe while idle");
  a_oe_after_fall: assert property (
    $rose(sio_oe_q != 4'h0) |-> !spi_sclk && $past(spi_sclk, 6))
    else $error("oe not after fall");
  a_sdr_hold: assert property (
    sio_oe_q == 4'h2 && $past(sio_oe_q) == 4'h2 &&
    sio_out_q != $past(sio_out_q) |-> !spi_sclk) else $error("sdr change");
  a_dtr_edge: assert property (
    sio_oe_q == 4'hf && $past(sio_oe_q) == 4'hf &&
    sio_out_q != $past(sio_out_q) |-> spi_sclk != $past(spi_sclk, 6))
    else $error("dtr change");
  a_busy_start: assert property (
    $rose(busy_q) |-> spi_cs_n && $past(spi_cs_n, 2)) else $error("busy start");
  a_busy_cap: assert property (
    busy_q |-> bcnt_q < 12'h880) else $error("busy too long");
  a_busy_len: assert property (
    $fell(busy_q) |-> bcnt_q == 12'h880) else $error("busy length");
endmodule // nrd_props
bind nrd_top nrd_props u_nrd_props (
  .clk_sys  (clk_sys),
  .sys_rst  (sys_rst),
  .clk_en   (clk_en),
  .spi_sclk (spi_sclk),
  .spi_cs_n (spi_cs_n),
  .sio_in   (sio_in),
  .sio_out_q(sio_out_q),
  .sio_oe_q (sio_oe_q),
  .busy_q   (busy_q)
);

// *** tb/nrd_host.sv ***
// Purpose: spi host model, mode 0, sclk half period 8 clk_sys cycles
// Assumes: dtr dummy count 4
// Notes:   released sio lines toggle every cycle since there is no pull
`timescale 1ns/1ps
module nrd_host (
  input  wire       clk_sys,
  input  wire [3:0] sio_out_q,
  input  wire [3:0] sio_oe_q,
  output reg        spi_sclk,
  output reg        spi_cs_n,
  output wire [3:0] sio_in
);
  reg [3:0] drv_q;
  reg [3:0] hoe_q;
  reg [3:0] seen_q;
  reg       flip_q;
  reg [7:0] rx [0:63];
  assign sio_in = (sio_oe_q & sio_out_q) | (~sio_oe_q & hoe_q & drv_q) |
                  (~sio_oe_q & ~hoe_q & {4{flip_q}});
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    drv_q = 4'h0;
    hoe_q = 4'h0;
    seen_q = 4'h0;
    flip_q = 1'b0;
  end
  always @(posedge clk_sys) begin
    flip_q <= ~flip_q;
    if (!spi_cs_n) seen_q <= seen_q | sio_oe_q;
  end
  // half period: data moves mid-half so it is stable at the edge
  task hp(input lv, input [3:0] d, output [3:0] s);
    begin
      repeat (4) @(posedge clk_sys);
      drv_q <= d;
      repeat (4) @(posedge clk_sys);
      s = sio_in;
      spi_sclk <= lv;
    end
  endtask
  task byte_x(input [7:0] o, output [7:0] r);
    integer i;
    reg [3:0] s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        hp(1'b0, {3'b110, o[i]}, s);
        hp(1'b1, {3'b110, o[i]}, s);
        r[i] = s[1];
      end
    end
  endtask
  task open_f;
    begin
      @(posedge clk_sys);
      spi_cs_n <= 1'b0;
      seen_q <= 4'h0;
      hoe_q <= 4'hd;
    end
  endtask
  task close_f;
    reg [3:0] s;
    begin
      hp(1'b0, drv_q, s);
      repeat (4) @(posedge clk_sys);
      spi_cs_n <= 1'b1;
      hoe_q <= 4'h0;
      repeat (16) @(posedge clk_sys);
    end
  endtask
  task sdr_cmd(input [7:0] op, input [31:0] a, input integer na,
               input integer nd, input integer nr);
    integer k;
    reg [7:0] r;
    begin
      open_f;
      byte_x(op, r);
      for (k = na - 1; k >= 0; k = k - 1) byte_x(a[8 * k +: 8], r);
      for (k = 0; k < nd; k = k + 1) byte_x(8'hff, r);
      for (k = 0; k < nr; k = k + 1) byte_x(8'hff, rx[k]);
      close_f;
    end
  endtask
  task dtr_cmd(input [15:0] col, input integer nr);
    integer k;
    reg [3:0] s;
    reg [7:0] r;
    begin
      open_f;
      byte_x(8'hee, r);
      hoe_q <= 4'hf;
      // first nibble rides the fall that follows the last opcode rise
      hp(1'b0, col[15:12], s);
      hp(1'b1, col[11:8], s);
      hp(1'b0, col[7:4], s);
      hp(1'b1, col[3:0], s);
      // release late so the last nibble holds past the sampling edge
      repeat (4) @(posedge clk_sys);
      hoe_q <= 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
        hp(1'b0, 4'h0, s);
        hp(1'b1, 4'h0, s);
      end
      // this fall makes the device present the first high nibble
      hp(1'b0, 4'h0, s);
      for (k = 0; k < nr; k = k + 1) begin
        hp(1'b1, 4'h0, rx[k][7:4]);
        hp(1'b0, 4'h0, rx[k][3:0]);
      end
      close_f;
    end
  endtask
endmodule // nrd_host

// *** tb/testbench.sv ***
// Purpose: self-checking bench of nrd_top through the host model
// Assumes: clk_sys 10 ns, sclk 160 ns
// Notes:   identity values are arbitrary
`timescale 1ns/1ps
module testbench;
  localparam [7:0]   MAKER = 8'ha7;
  localparam [7:0]   PART  = 8'h61;
  localparam [127:0] UIDV  = 128'h00112233445566778899aabbccddeeff;
  reg        clk_sys;
  reg        sys_rst;
  reg        clk_en;
  wire       spi_sclk;
  wire       spi_cs_n;
  wire [3:0] sio_in;
  wire [3:0] sio_out_q;
  wire [3:0] sio_oe_q;
  wire       busy_q;
  integer    n_fail;
  integer    n_compared;
  nrd_top #(.MAKER_CODE(MAKER), .PART_CODE(PART), .UID_VALUE(UIDV)) u_nrd_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .sio_in(sio_in),
    .sio_out_q(sio_out_q), .sio_oe_q(sio_oe_q), .busy_q(busy_q));
  nrd_host u_nrd_host (
    .clk_sys(clk_sys), .sio_out_q(sio_out_q), .sio_oe_q(sio_oe_q),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .sio_in(sio_in));
  always #5 clk_sys = ~clk_sys;
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("unexpected %s: expected %h seen %h", what, exp, got);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task wait_ready;
    integer t;
    begin
      t = 0;
      u_nrd_host.sdr_cmd(8'h0f, 32'hc0, 1, 0, 1);
      while (u_nrd_host.rx[0][0] !== 1'b0 && t < 20) begin
        u_nrd_host.sdr_cmd(8'h0f, 32'hc0, 1, 0, 1);
        t = t + 1;
      end
      if (u_nrd_host.rx[0][0] !== 1'b0) begin
        $display("unexpected ready: expected 0 seen 1");
        n_fail = n_fail + 1;
        test_done;
      end
    end
  endtask
  task t_id;
    integer k;
    begin
      u_nrd_host.sdr_cmd(8'h9f, 32'h0, 1, 0, 4);
      chk("oe sdr", 8'h02, {4'h0, u_nrd_host.seen_q});
      for (k = 0; k < 4; k = k + 1) begin
        chk("id", k[0] ? PART : MAKER, u_nrd_host.rx[k]);
      end
      u_nrd_host.sdr_cmd(8'h9f, 32'h1, 1, 0, 1);
      chk("id addr", 8'h00, u_nrd_host.rx[0]);
      $display("test id done");
    end
  endtask
  task t_dtr;
    integer k;
    begin
      u_nrd_host.dtr_cmd(16'h087e, 2);
      chk("oe refused", 8'h00, {4'h0, u_nrd_host.seen_q});
      u_nrd_host.sdr_cmd(8'h1f, 32'hb001, 2, 0, 0);
      u_nrd_host.sdr_cmd(8'h13, 32'h45, 3, 0, 0);
      wait_ready;
      u_nrd_host.dtr_cmd(16'h087e, 4);
      chk("oe dtr", 8'h0f, {4'h0, u_nrd_host.seen_q});
      for (k = 0; k < 4; k = k + 1) begin
        chk("dtr byte", 8'h45 ^ ((k < 2) ? 8'h7e + k[7:0] : k[7:0] - 8'h02),
            u_nrd_host.rx[k]);
      end
      $display("test dtr done");
    end
  endtask
  task t_uid;
    integer k;
    reg [7:0] u;
    begin
      u_nrd_host.sdr_cmd(8'h1f, 32'hb040, 2, 0, 0);
      u_nrd_host.sdr_cmd(8'h0f, 32'hb0, 1, 0, 1);
      chk("cfg", 8'h40, u_nrd_host.rx[0]);
      u_nrd_host.sdr_cmd(8'h13, 32'h06, 3, 0, 0);
      // a frozen clock enable must hold busy past a whole load time
      clk_en <= 1'b0;
      repeat (2200) @(posedge clk_sys);
      chk("busy frozen", 8'h01, {7'h0, busy_q});
      clk_en <= 1'b1;
      chk("busy pin", 8'h01, {7'h0, busy_q});
      u_nrd_host.sdr_cmd(8'h03, 32'h0, 2, 1, 1);
      chk("busy data", 8'hff, u_nrd_host.rx[0]);
      u_nrd_host.sdr_cmd(8'h0f, 32'hc0, 1, 0, 1);
      chk("busy flag", 8'h01, {7'h0, u_nrd_host.rx[0][0]});
      wait_ready;
      u_nrd_host.sdr_cmd(8'h03, 32'h0, 2, 1, 34);
      for (k = 0; k < 34; k = k + 1) begin
        u = UIDV[127 - 8 * (k % 16) -: 8];
        chk("uid", (k % 32) < 16 ? u : ~u, u_nrd_host.rx[k]);
      end
      for (k = 0; k < 16; k = k + 1) begin
        chk("uid xor", 8'hff, u_nrd_host.rx[k] ^ u_nrd_host.rx[k + 16]);
      end
      u_nrd_host.sdr_cmd(8'h0b, 32'h1fe, 2, 1, 4);
      for (k = 0; k < 4; k = k + 1) begin
        u = UIDV[127 - 8 * ((14 + k) % 16) -: 8];
        chk("uid tail", k < 2 ? ~u : 8'hff, u_nrd_host.rx[k]);
      end
      $display("test uid done");
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    t_id;
    t_dtr;
    t_uid;
    test_done;
  end
endmodule // testbench
